/* File: rtl/repeater_port_arbitration.sv */
// Port arbitration and data repetition core of one repeater chip.
// Assumes port activity, grant input, activity line and decoder
// outputs are asynchronous pins; the collision state comes from
// the chip's own main state machine on the system clock.
`timescale 1ns/1ps
module repeater_port_arbitration (
    input  wire logic                                clock,
    input  wire logic                                nrst,
    input  wire logic [repeater_pkg::PORT_COUNT-1:0] rx_active,
    input  wire logic [repeater_pkg::PORT_COUNT-1:0] col_active,
    input  wire logic                                tx_col_state,
    input  wire logic                                chain_grant_in,
    output logic                                     chain_grant_out,
    input  wire logic                                active_port_line_in,
    output logic                                     active_port_line_out,
    output logic                                     active_port_line_en_n,
    input  wire logic                                decoded_data,
    input  wire logic                                pll_locked,
    input  wire logic                                relay_clock,
    input  wire logic                                relay_data,
    input  wire logic                                relay_frame_enable,
    output logic                                     relay_data_out,
    output logic                                     relay_clock_out,
    output logic                                     relay_frame_enable_out,
    output logic                                     relay_en_n,
    output logic [repeater_pkg::PORT_COUNT-1:0]      port_n,
    output logic [repeater_pkg::PORT_COUNT-1:0]      port_m,
    output logic                                     tx_data,
    output logic [repeater_pkg::PORT_COUNT-1:0]      tx_enable,
    output logic                                     bus_repeat,
    output logic                                     bus_idle,
    output logic                                     rx_collision
);
    import repeater_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_STARTUP  = 3'b001,
        ST_PREAMBLE = 3'b010,
        ST_DATA     = 3'b011,
        ST_RXCOL    = 3'b100,
        ST_WAIT     = 3'b101
    } rep_state_type;

    typedef struct packed {
        rep_state_type         state;
        logic [1:0]            grant_sync;
        logic [1:0]            act_sync;
        logic [1:0]            lock_sync;
        logic [1:0]            data_sync;
        logic [PORT_COUNT-1:0] rx_meta;
        logic [PORT_COUNT-1:0] rx_sync;
        logic [PORT_COUNT-1:0] col_meta;
        logic [PORT_COUNT-1:0] col_sync;
        logic [2:0]            toggle_sync;
        logic                  tx_col_prev;
        logic [PORT_COUNT-1:0] port_n;
        logic [PORT_COUNT-1:0] port_m;
        logic [15:0]           timer;
        logic [3:0]            bit_phase;
        logic [7:0]            bits_sent;
        logic [5:0]            preamble;
        logic [7:0]            shift;
        logic [3:0]            shift_left;
        logic                  pending;
        logic [7:0]            pending_byte;
        logic                  tx_data;
        logic [PORT_COUNT-1:0] tx_enable;
        logic                  grant_out;
        logic                  act_en_n;
        logic                  relay_en_n;
        logic                  relay_clk;
        logic                  relay_dat;
        logic                  relay_fe;
        logic                  bus_repeat;
        logic                  bus_idle;
        logic                  rx_collision;
    } core_state_type;

    core_state_type s;
    core_state_type next_s;

    relay_byte_if rb ();

    // ------------------------------------------------------------------
    // Relay receive side
    // ------------------------------------------------------------------
    relay_capture u_capture (
        .relay_clock        (relay_clock),
        .nrst               (nrst),
        .relay_data         (relay_data),
        .relay_frame_enable (relay_frame_enable),
        .lnk                (rb.link)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic                  grant_ok;
    logic                  activity;
    logic                  tick;
    logic                  holder;
    logic                  own_live;
    logic                  frame_live;
    logic                  busy;
    logic                  drive;
    logic [PORT_COUNT-1:0] req;

    always_comb begin
        next_s = s;

        // Two flip-flops on every asynchronous pin before any logic looks at it.
        next_s.grant_sync  = {s.grant_sync[0], chain_grant_in};
        next_s.act_sync    = {s.act_sync[0], active_port_line_in};
        next_s.lock_sync   = {s.lock_sync[0], pll_locked};
        next_s.data_sync   = {s.data_sync[0], decoded_data};
        next_s.rx_meta     = rx_active;
        next_s.rx_sync     = s.rx_meta;
        next_s.col_meta    = col_active;
        next_s.col_sync    = s.col_meta;
        next_s.toggle_sync = {s.toggle_sync[1:0], rb.toggle};
        next_s.tx_col_prev = tx_col_state;

        grant_ok = s.grant_sync[1];
        activity = ~s.act_sync[1];
        holder   = |s.port_n;
        own_live = |((s.rx_sync | s.col_sync) & s.port_n);
        frame_live = holder ? own_live : activity;

        // Bit timer runs free; the relay clock is divided from it.
        tick = (s.bit_phase == BIT_CYC - 4'd1);
        next_s.bit_phase = tick ? 4'd0 : s.bit_phase + 4'd1;
        next_s.relay_clk = (next_s.bit_phase < HALF_BIT);

        // Requests into the chain, in priority order.
        if (s.state == ST_IDLE) begin
            req = s.rx_sync | s.col_sync;
        end else if (tx_col_state) begin
            req = s.col_sync;
        end else begin
            req = '0;
        end

        // Grant passes downward only past a chip with no claim.
        next_s.grant_out = grant_ok & ~(|req)
                           & ~holder & ~(|s.port_m);

        // Colliding port is fixed as the collision state ends.
        if (s.tx_col_prev && !tx_col_state) begin
            next_s.port_m = grant_ok ? first_set(s.col_sync)
                                     : '0;
        end

        // Only bits that reach the ports count toward the minimum.
        if (tick && s.bits_sent != 8'hFF
            && (s.state == ST_PREAMBLE || s.state == ST_DATA
                || s.state == ST_RXCOL)) begin
            next_s.bits_sent = s.bits_sent + 8'd1;
        end

        unique case (s.state)
            ST_IDLE: begin
                next_s.bits_sent = '0;
                next_s.timer     = '0;
                if (|req || activity) begin
                    next_s.state  = ST_STARTUP;
                    next_s.port_n = grant_ok ? first_set(req)
                                             : '0;
                end
            end
            ST_STARTUP: begin
                // The start-up delay covers the chain settling.
                if (s.timer < STARTUP_CYC) begin
                    next_s.timer = s.timer + 16'd1;
                end else if (tick) begin
                    next_s.state     = ST_PREAMBLE;
                    next_s.preamble  = '0;
                    next_s.tx_data   = 1'b0;
                    next_s.tx_enable = ~s.port_n;
                end
            end
            ST_PREAMBLE: begin
                if (tick) begin
                    next_s.tx_data  = ~s.preamble[0];
                    next_s.preamble = s.preamble + 6'd1;
                    if (s.preamble == PREAMBLE_BITS - 6'd1) begin
                        next_s.state      = ST_DATA;
                        next_s.shift      = SFD_BYTE;
                        next_s.shift_left = 4'd8;
                    end
                end
            end
            ST_DATA: begin
                if (tick) begin
                    if (s.shift_left != 4'd0) begin
                        next_s.tx_data    = s.shift[0];
                        next_s.shift      = {1'b0, s.shift[7:1]};
                        next_s.shift_left = s.shift_left - 4'd1;
                    end else if (s.pending) begin
                        // Buffer drains only behind the preamble.
                        next_s.tx_data    = s.pending_byte[0];
                        next_s.shift      = {1'b0, s.pending_byte[7:1]};
                        next_s.shift_left = 4'd7;
                        next_s.pending    = 1'b0;
                    end else if (!activity) begin
                        next_s.state = ST_WAIT;
                        next_s.timer = '0;
                    end
                end
            end
            ST_RXCOL: begin
                if (tick) begin
                    next_s.tx_data = ~s.tx_data;
                    if (s.bits_sent >= MIN_BITS && !frame_live) begin
                        next_s.state = ST_WAIT;
                        next_s.timer = '0;
                    end
                end
            end
            ST_WAIT: begin
                next_s.tx_enable = '0;
                next_s.port_n    = '0;
                next_s.port_m    = '0;
                next_s.pending   = 1'b0;
                if (s.timer < TW1_CYC) begin
                    next_s.timer = s.timer + 16'd1;
                end else begin
                    next_s.state = ST_IDLE;
                end
            end
            default: begin
                next_s.state = ST_IDLE;
            end
        endcase

        // Short frames are padded with jam up to the minimum.
        if ((s.state == ST_PREAMBLE || s.state == ST_DATA)
            && !frame_live && s.bits_sent < MIN_BITS) begin
            next_s.state = ST_RXCOL;
        end

        // A byte arriving as the last one leaves is still kept.
        if (s.toggle_sync[2] != s.toggle_sync[1]) begin
            next_s.pending      = 1'b1;
            next_s.pending_byte = rb.data_byte;
        end

        busy = (next_s.state != ST_IDLE) && (next_s.state != ST_WAIT);

        // Winner drives activity; its relay lines follow lock.
        next_s.act_en_n = ~(busy && |next_s.port_n);
        drive = busy && (|next_s.port_n) && s.lock_sync[1]
                && own_live;
        next_s.relay_en_n = ~drive;
        next_s.relay_fe   = drive;
        if (tick) begin
            next_s.relay_dat = s.data_sync[1];
        end

        next_s.bus_repeat   = (next_s.state == ST_PREAMBLE)
                              || (next_s.state == ST_DATA);
        next_s.bus_idle     = (next_s.state == ST_IDLE)
                              || (next_s.state == ST_WAIT);
        next_s.rx_collision = (next_s.state == ST_RXCOL);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            // Synchronisers start at the idle pin levels, so that no
            // false claim or activity follows reset.
            s <= '{state: ST_IDLE,
                   grant_sync: {2{GRANT_OUT_RESET}},
                   act_sync: {2{DRIVE_N_RESET}},
                   grant_out: GRANT_OUT_RESET,
                   act_en_n: DRIVE_N_RESET,
                   relay_en_n: DRIVE_N_RESET,
                   bus_idle: 1'b1,
                   default: '0};
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Low output with high input marks the winning chip.
    assign chain_grant_out        = s.grant_out;
    assign active_port_line_out   = 1'b0;
    assign active_port_line_en_n  = s.act_en_n;
    assign relay_data_out         = s.relay_dat;
    assign relay_clock_out        = s.relay_clk;
    assign relay_frame_enable_out = s.relay_fe;
    assign relay_en_n             = s.relay_en_n;
    assign port_n                 = s.port_n;
    assign port_m                 = s.port_m;
    assign tx_data                = s.tx_data;
    assign tx_enable              = s.tx_enable;
    assign bus_repeat             = s.bus_repeat;
    assign bus_idle               = s.bus_idle;
    assign rx_collision           = s.rx_collision;

endmodule : repeater_port_arbitration

/* File: rtl/repeater_pkg.sv */
// Constants, timing counts and shared helpers for the repeater port
// arbitration block. Assumes a 100 MHz system clock and 10 Mb/s data.
//
// How it works
// - Port 1 highest, port 13 lowest priority.
// - Grant input tops chain; chain bottom drives output.
// - In IDLE pick highest active receiving port.
// - Leaving transmit collision, pick highest colliding port.
// - Receive activity in IDLE asserts grant output.
// - Same arbitration finds colliding port in collision.
// - Activity start drives grant and activity lines.
// - One port granted; all others transmit.
// - Repeated packets start with generated preamble.
// - After lock, winner drives relay data, clock, enable.
// - Relay stream loads buffer only after SFD.
// - Buffered data sent only after preamble done.
// - Arbitrate during start-up delay, then send preamble.
// - Bus shows merged REPEAT and merged IDLE states.
// - Send at least 96 bits; short frames extended.
// - After emptying buffers, wait recovery time in WAIT.
// - Winning chip drives the wired-OR activity line.
// - Winner shows output low while input high.
// - Only the winning chip drives relay data.
package repeater_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int PORT_COUNT = 13;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLOCK_NS   = 10;
    localparam int BIT_NS     = 100;
    localparam int STARTUP_NS = 400;
    localparam int TW1_NS     = 1000;

    localparam logic [3:0]  BIT_CYC     = 4'(BIT_NS / CLOCK_NS);
    localparam logic [3:0]  HALF_BIT    = 4'(BIT_NS / CLOCK_NS / 2);
    localparam logic [15:0] STARTUP_CYC =
        16'((STARTUP_NS + CLOCK_NS - 1) / CLOCK_NS);
    localparam logic [15:0] TW1_CYC     =
        16'((TW1_NS + CLOCK_NS - 1) / CLOCK_NS);

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam logic [7:0] MIN_BITS      = 8'h60;
    localparam logic [5:0] PREAMBLE_BITS = 6'h38;
    localparam logic [7:0] SFD_BYTE      = 8'hD5;

    // ------------------------------------------------------------------
    // Reset levels of the inter-chip lines
    // ------------------------------------------------------------------
    localparam logic GRANT_OUT_RESET = 1'b1;
    localparam logic DRIVE_N_RESET   = 1'b1;

    // Highest-priority set bit: bit 0 is port 1.
    function automatic logic [PORT_COUNT-1:0] first_set(
        input logic [PORT_COUNT-1:0] v
    );
        first_set = '0;
        for (int i = PORT_COUNT - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set    = '0;
                first_set[i] = 1'b1;
            end
        end
    endfunction : first_set

endpackage : repeater_pkg

/* File: rtl/relay_byte_if.sv */
// Carrier for bytes caught on the relay clock and handed to the core.
// Assumes the byte stays stable for eight relay clocks after a toggle.
`timescale 1ns/1ps
interface relay_byte_if;
    logic [7:0] data_byte;
    logic       toggle;

    modport link (output data_byte, output toggle);
    modport core (input data_byte, input toggle);
endinterface : relay_byte_if

/* File: rtl/relay_capture.sv */
// Relay-clock side of the elasticity buffer: hunts the SFD in the
// relayed stream and hands each later byte over with a toggle.
// Assumes the relay clock runs while the frame enable is high.
`timescale 1ns/1ps
module relay_capture
    import repeater_pkg::*;
(
    input  wire logic  relay_clock,
    input  wire logic  nrst,
    input  wire logic  relay_data,
    input  wire logic  relay_frame_enable,
    relay_byte_if.link lnk
);

    typedef struct packed {
        logic [7:0] hunt;
        logic       found;
        logic [2:0] count;
        logic [7:0] data_byte;
        logic       toggle;
    } link_state_type;

    link_state_type s;
    link_state_type next_s;
    logic [7:0]     shifted;

    // ------------------------------------------------------------------
    // Byte assembly
    // ------------------------------------------------------------------
    always_comb begin
        next_s  = s;
        shifted = {relay_data, s.hunt[7:1]};
        if (!relay_frame_enable) begin
            next_s.hunt  = '0;
            next_s.found = 1'b0;
            next_s.count = '0;
        end else begin
            next_s.hunt = shifted;
            if (!s.found) begin
                // Nothing is loaded before the delimiter.
                if (shifted == SFD_BYTE) begin
                    next_s.found = 1'b1;
                    next_s.count = '0;
                end
            end else begin
                next_s.count = s.count + 3'd1;
                if (s.count == 3'd7) begin
                    next_s.data_byte = shifted;
                    next_s.toggle    = ~s.toggle;
                end
            end
        end
    end

    always_ff @(posedge relay_clock or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign lnk.data_byte = s.data_byte;
    assign lnk.toggle    = s.toggle;

endmodule : relay_capture

/* File: dv/repeater_port_arbitration_monitor.sv */
// Concurrent checks on the ports of the repeater arbitration block.
// Assumes the system clock and the active-low reset of that block.
`timescale 1ns/1ps
module repeater_port_arbitration_monitor (
    input wire logic                                clock,
    input wire logic                                nrst,
    input wire logic                                chain_grant_in,
    input wire logic                                chain_grant_out,
    input wire logic                                active_port_line_en_n,
    input wire logic                                relay_en_n,
    input wire logic [repeater_pkg::PORT_COUNT-1:0] port_n,
    input wire logic [repeater_pkg::PORT_COUNT-1:0] tx_enable,
    input wire logic                                bus_repeat,
    input wire logic                                bus_idle,
    input wire logic                                rx_collision
);
    import repeater_pkg::*;

    // Cycles since the bus left its idle state; saturates.
    logic [15:0] since;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            since <= '0;
        end else if (bus_idle) begin
            since <= '0;
        end else if (since != 16'hffff) begin
            since <= since + 16'h0001;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    a_reset_lines_idle: assert property ($rose(nrst) |-> chain_grant_out
        && active_port_line_en_n && relay_en_n && bus_idle && port_n == '0)
        else $error("lines not idle after reset");
    a_state_merge: assert property (!(bus_repeat && bus_idle))
        else $error("repeat and idle together");
    a_port_n_single: assert property ($onehot0(port_n))
        else $error("more than one receiving port");
    a_others_send: assert property ((tx_enable & port_n) == '0)
        else $error("receiving port transmits");
    a_winner_claims: assert property (!active_port_line_en_n |-> !chain_grant_out)
        else $error("activity driven without claim");
    a_claim_on_start: assert property ($fell(bus_idle) && port_n != '0
        |-> !chain_grant_out && !active_port_line_en_n)
        else $error("start without claim");
    a_relay_owner: assert property (!relay_en_n |-> port_n != '0)
        else $error("relay driven without receiving port");
    a_pass_grant: assert property ((!chain_grant_in)[*5] |-> !chain_grant_out)
        else $error("claim from above not passed on");
    a_startup_delay: assert property ($rose(bus_repeat) |-> since >= STARTUP_CYC)
        else $error("preamble before start-up delay");
    a_min_length: assert property ($rose(bus_idle)
        |-> since >= STARTUP_CYC + 16'(MIN_BITS) * 16'(BIT_CYC))
        else $error("repeat shorter than minimum");

    cover property ($rose(bus_repeat));
    cover property ($rose(rx_collision));
    cover property ($fell(relay_en_n));

endmodule : repeater_port_arbitration_monitor

/* File: dv/relay_partner.sv */
// Model of an upper cascaded chip that holds the receiving port.
// Assumes the system clock is given; the relay clock is its own.
`timescale 1ns/1ps
module relay_partner (
    input  wire logic clock,
    output logic      relay_clock,
    output logic      relay_data,
    output logic      relay_frame_enable,
    output logic      line_n,
    output logic      grant
);
    initial begin
        relay_clock = 1'b0;
        relay_data = 1'b0;
        relay_frame_enable = 1'b0;
        line_n = 1'b1;
        grant = 1'b1;
    end

    // The relay clock runs inside a frame and for one trailing bit after it, 15 ns a bit.
    task automatic send_bits(input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            relay_data = v[i];
            #7.5 relay_clock = 1'b1;
            #7.5 relay_clock = 1'b0;
        end
    endtask : send_bits

    task automatic send_frame(input logic [7:0] b, input int lead,
                              input int hold);
        @(posedge clock);
        grant <= 1'b0;
        line_n <= 1'b0;
        repeat (lead) @(posedge clock);
        relay_frame_enable = 1'b1;
        send_bits(32'h0055_5555, 24);
        send_bits(32'h0000_00d5, 8);
        send_bits({24'h00_0000, b}, 8);
        relay_frame_enable = 1'b0;
        // A released line must not keep showing its last bit; one
        // trailing clock with the enable low ends the delimiter hunt.
        send_bits({31'h0000_0000, ~relay_data}, 1);
        repeat (hold) @(posedge clock);
        line_n <= 1'b1;
        grant <= 1'b1;
    endtask : send_frame
endmodule : relay_partner

/* File: dv/testbench.sv */
// Self-checking bench for the repeater arbitration block.
// Assumes the partner model and checker files are compiled first.
`timescale 1ns/1ps
module testbench;
    import repeater_pkg::*;
    logic                  clock, nrst, tx_col_state, pll_locked;
    logic                  decoded_data, chain_grant_out, tx_data;
    logic                  active_port_line_out, active_port_line_en_n;
    logic                  relay_clock, relay_data, relay_frame_enable;
    logic                  relay_data_out, relay_clock_out, relay_en_n;
    logic                  relay_frame_enable_out, bus_repeat, bus_idle;
    logic                  rx_collision, far_line_n, far_grant;
    logic [PORT_COUNT-1:0] rx_active, col_active, port_n, port_m, tx_enable;
    int                    mismatches, checked;
    wire                   line = (active_port_line_en_n ? 1'b1 :
                                   active_port_line_out) & far_line_n;

    repeater_port_arbitration dut_u (.clock, .nrst, .rx_active, .col_active,
        .tx_col_state, .chain_grant_in(far_grant), .chain_grant_out,
        .active_port_line_in(line), .active_port_line_out,
        .active_port_line_en_n, .decoded_data, .pll_locked, .relay_clock,
        .relay_data, .relay_frame_enable, .relay_data_out, .relay_clock_out,
        .relay_frame_enable_out, .relay_en_n, .port_n, .port_m, .tx_data,
        .tx_enable, .bus_repeat, .bus_idle, .rx_collision);
    relay_partner far_u (.clock, .relay_clock, .relay_data,
        .relay_frame_enable, .line_n(far_line_n), .grant(far_grant));

    always #5 clock = ~clock;
    always @(posedge clock) decoded_data <= ~decoded_data;

    task automatic check(input logic [71:0] seen, input logic [71:0] want);
        checked++;
        if (seen !== want) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, want);
        end
    endtask : check

    task automatic give_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Waits until the repeat ends, then lets the recovery wait pass.
    task automatic wait_quiet(output logic jam);
        int i;
        jam = 1'b0;
        for (i = 0; i < 5000; i++) begin
            @(negedge clock);
            if (rx_collision === 1'b1) jam = 1'b1;
            if (bus_idle === 1'b1 && chain_grant_out === 1'b1 &&
                far_line_n === 1'b1) break;
        end
        check(i < 5000, 1'b1);
        repeat (int'(TW1_CYC) + 20) @(negedge clock);
    endtask : wait_quiet

    task automatic wait_repeat;
        int i;
        for (i = 0; i < 200 && bus_repeat !== 1'b1; i++) @(negedge clock);
        check(bus_repeat, 1'b1);
    endtask : wait_repeat

    task automatic test_reset;
        @(negedge clock);
        check(chain_grant_out, 1'b1);
        check(active_port_line_en_n, 1'b1);
        check({relay_en_n, bus_idle, port_n}, {2'b11, 13'h0000});
    endtask : test_reset

    task automatic test_own_frame;
        logic jam;
        int   hi = 0;
        @(posedge clock);
        rx_active <= 13'h0210;
        repeat (4) @(negedge clock);
        check(port_n, 13'h0010);
        check(chain_grant_out, 1'b0);
        check(active_port_line_en_n, 1'b0);
        repeat (10) @(negedge clock);
        check({relay_en_n, relay_frame_enable_out}, 2'b01);
        for (int i = 0; i < int'(BIT_CYC); i++) begin
            @(negedge clock);
            hi += relay_clock_out;
        end
        check(hi, int'(HALF_BIT));
        @(posedge clock);
        col_active <= 13'h0044;
        tx_col_state <= 1'b1;
        repeat (6) @(posedge clock);
        tx_col_state <= 1'b0;
        repeat (4) @(negedge clock);
        check(port_m, 13'h0004);
        @(posedge clock);
        col_active <= '0;
        wait_repeat();
        check(tx_enable, 13'h1fef);
        @(posedge clock);
        rx_active <= '0;
        wait_quiet(jam);
        check(jam, 1'b1);
        check(port_n, 13'h0000);
    endtask : test_own_frame

    task automatic test_repeat;
        logic        jam;
        logic [71:0] got;
        fork
            far_u.send_frame(8'h3c, 8, 1300);
        join_none
        repeat (8) @(negedge clock);
        check(chain_grant_out, 1'b0);
        check(port_n, 13'h0000);
        wait_repeat();
        check({bus_idle, tx_enable}, {1'b0, 13'h1fff});
        repeat (int'(BIT_CYC) + 4) @(negedge clock);
        for (int i = 0; i < 72; i++) begin
            got[i] = tx_data;
            repeat (int'(BIT_CYC)) @(negedge clock);
        end
        check(got, {8'h3c, 8'hd5, 56'h55_5555_5555_5555});
        check(relay_en_n, 1'b1);
        wait_quiet(jam);
        check(bus_idle, 1'b1);
    endtask : test_repeat

    initial begin
        clock = 1'b0;
        nrst = 1'b0;
        rx_active = '0;
        col_active = '0;
        tx_col_state = 1'b0;
        pll_locked = 1'b1;
        decoded_data = 1'b0;
        mismatches = 0;
        checked = 0;
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        test_reset();
        test_own_frame();
        test_repeat();
        give_verdict();
    end

    // The tests need some 30 us; this cuts a hang short.
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end
endmodule : testbench

bind repeater_port_arbitration repeater_port_arbitration_monitor mon_u (
    .clock, .nrst, .chain_grant_in, .chain_grant_out, .active_port_line_en_n,
    .relay_en_n, .port_n, .tx_enable, .bus_repeat, .bus_idle, .rx_collision);
